// [rtl/hprc_defs.svh]
// Constant definitions for the hibernate power and seconds-counter controller
`ifndef HPRC_DEFS_SVH
`define HPRC_DEFS_SVH
// Register offsets (byte addresses)
`define HPRC_OFF_COUNT 12'h000
`define HPRC_OFF_MATCH0 12'h004
`define HPRC_OFF_MATCH1 12'h008
`define HPRC_OFF_LOAD 12'h00c
`define HPRC_OFF_CTRL 12'h010
`define HPRC_OFF_MASK 12'h014
`define HPRC_OFF_RAW 12'h018
`define HPRC_OFF_MIS 12'h01c
`define HPRC_OFF_CLEAR 12'h020
`define HPRC_OFF_TRIM 12'h024
`define HPRC_OFF_DATA_LO 12'h030
`define HPRC_OFF_DATA_HI 12'h12c
// Control bit positions
`define HPRC_CTL_HIBREQ 1
`define HPRC_CTL_SEL 2
`define HPRC_CTL_MWAKE 3
`define HPRC_CTL_PWAKE 4
`define HPRC_CTL_LBEN 5
`define HPRC_CTL_CLKEN 6
`define HPRC_CTL_ABORT 7
`define HPRC_CTL_CNTEN 0
// Event bit positions
`define HPRC_EV_M0 0
`define HPRC_EV_M1 1
`define HPRC_EV_LB 2
`define HPRC_EV_WAKE 3
// Reset values and divider constants
`define HPRC_RST_MATCH 32'hffffffff
`define HPRC_RST_TRIM 16'h7fff
`define HPRC_NOMINAL_DIV 16'h7fff
`define HPRC_XTAL_DIV 7'h7f
`define HPRC_TRIM_PERIOD 6'h3f
`endif

// [rtl/hprc_pkg.sv]
// Types shared by the hibernate power controller files
package hprc_pkg;
    // One write carried into the slow domain
    typedef struct packed {
        logic [11:0] addr;
        logic [31:0] data;
    } hprc_wr_t;
    // Power state machine
    typedef enum logic [1:0] {
        HPRC_AWAKE = 2'b00,
        HPRC_HIBERNATE = 2'b01,
        HPRC_WAKING = 2'b10
    } hprc_state_t;
endpackage

// [rtl/hprc_retained_mem.sv]
// Retained word storage with registered read data
`timescale 1ns/1ps
module hprc_retained_mem #(
    parameter int DEPTH = 64,
    parameter int AW = 6
) (
    input wire logic clk,
    input wire logic wrEn,
    input wire logic [AW-1:0] wrAddr,
    input wire logic [31:0] wrData,
    input wire logic [AW-1:0] rdAddr,
    output logic [31:0] rdData
);
    // Storage array, kept through hibernation on backup supply
    logic [31:0] mem [DEPTH];
    // Write port
    always_ff @(posedge clk) begin
        if (wrEn) begin
            mem[wrAddr] <= wrData;
        end
    end
    // Registered read port
    always_ff @(posedge clk) begin
        rdData <= mem[rdAddr];
    end
endmodule // hprc_retained_mem

// [rtl/hprc_sync.sv]
// Three-stage synchroniser; a change is taken once stages two and three agree
`timescale 1ns/1ps
module hprc_sync #(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic [W-1:0] din,
    output logic [W-1:0] dout
);
    // Synchroniser stages
    logic [W-1:0] s1Q;
    logic [W-1:0] s2Q;
    logic [W-1:0] s3Q;
    // Shift chain; only s2 reads s1
    always_ff @(posedge clk) begin
        if (srst) begin
            s1Q <= '0;
            s2Q <= '0;
            s3Q <= '0;
            dout <= '0;
        end else begin
            s1Q <= din;
            s2Q <= s1Q;
            s3Q <= s2Q;
            for (int i = 0; i < W; i++) begin
                if (s2Q[i] == s3Q[i]) begin
                    dout[i] <= s3Q[i];
                end
            end
        end
    end
endmodule // hprc_sync

// [rtl/hprc_controller.sv]
// Hibernate power controller: registers, seconds counter, wake and power logic
//
// Strobed register access and the register offsets were left to the implementer.
`timescale 1ns/1ps
`include "hprc_defs.svh"
module hprc_controller #(
    parameter int MEM_DEPTH = 64
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic [11:0] addr,
    input wire logic [31:0] wrData,
    input wire logic wrStb,
    input wire logic rdStb,
    output logic [31:0] rdData,
    input wire logic xtalTick,
    input wire logic oscTick,
    input wire logic wakePin_n,
    input wire logic lowBatteryDet,
    output logic regulatorOff_n,
    output logic eventIrq,
    output logic slowClockEnable,
    output logic chipPorReset
);
    // Behaviour notes for the next maintainer:
    // - The slow domain is modelled as tick inputs sampled on clk, so every
    //   register here lives on clk; software spacing of slow-domain accesses
    //   is not needed for correctness in this model, but callers keep it.
    // - Raw events are sticky; a new event in the same cycle as its clear wins.
    // - Match events stand for as long as the counter equals a match value and
    //   the counter is enabled, so a clear while it still matches is undone.
    // - Hibernation is entered one cycle after the request bit is seen with a
    //   wake source armed; the regulator enable follows one cycle later.
    // - A wake passes through one waking cycle that raises the chip reset pulse
    //   and drops the request bit, so the woken software does not re-enter.
    // - The low-battery event is masked while hibernating: nothing is measured
    //   while the main supply is off.
    // - The load register has no storage of its own; reading it returns the count.
    // - Reserved bits read as zero and unmapped writes are ignored.
    // Control and other register fields, counters and power state
    logic [7:0] ctlQ;
    logic [31:0] match0Q;
    logic [31:0] match1Q;
    logic [15:0] trimQ;
    logic [3:0] maskQ;
    logic [3:0] rawQ;
    logic [31:0] countQ;
    logic [15:0] predivQ;
    logic [5:0] trimSecQ;
    logic [6:0] xdivQ;
    hprc_pkg::hprc_state_t stateQ;
    // Synchronised pin inputs
    logic wakeSync;
    logic lbSync;
    logic xtalSync;
    logic oscSync;
    logic xtalPrevQ;
    logic oscPrevQ;
    // Decoded accesses
    logic inData;
    logic [5:0] memIdx;
    logic [31:0] memRd;
    logic rdDataSelQ;
    logic [31:0] regRdQ;
    logic regulator_off_n;
    logic refTick;
    logic secTick;
    logic [3:0] ev;
    logic [3:0] clrBits;
    // Write strobes decoded per register
    logic wrCtl; // Control register write
    logic wrLoad; // Counter load write
    logic wrClear; // Event clear write
    logic wrMatch0; // First match register write
    logic wrMatch1; // Second match register write
    logic wrTrim; // Predivider trim write
    logic wrMask; // Event mask write
    // Wake and entry conditions
    logic pinWake; // Armed pin is asserted
    logic matchWake; // Armed match is present
    logic entryOk; // Request may be honoured

    // Pins and reference ticks from outside the clock domain; this single-clock
    // build carries the slow-domain crossing as these synchronisers
    hprc_sync #(.W(4)) uPinSync (
        .clk(clk),
        .srst(srst),
        .din({~wakePin_n, lowBatteryDet, xtalTick, oscTick}),
        .dout({wakeSync, lbSync, xtalSync, oscSync})
    );

    assign inData = (addr >= `HPRC_OFF_DATA_LO) && (addr <= `HPRC_OFF_DATA_HI);
    assign memIdx = 6'((addr - `HPRC_OFF_DATA_LO) >> 2);
    assign regulator_off_n = (stateQ == hprc_pkg::HPRC_HIBERNATE);
    assign clrBits = wrClear ? wrData[3:0] : 4'h0;

    // One strobe per writable register
    assign wrCtl = wrStb && (addr == `HPRC_OFF_CTRL);
    assign wrLoad = wrStb && (addr == `HPRC_OFF_LOAD);
    assign wrClear = wrStb && (addr == `HPRC_OFF_CLEAR);
    assign wrMatch0 = wrStb && (addr == `HPRC_OFF_MATCH0);
    assign wrMatch1 = wrStb && (addr == `HPRC_OFF_MATCH1);
    assign wrTrim = wrStb && (addr == `HPRC_OFF_TRIM);
    assign wrMask = wrStb && (addr == `HPRC_OFF_MASK);

    // Wake sources are looked at only when armed
    assign pinWake = ctlQ[`HPRC_CTL_PWAKE] && wakeSync;
    assign matchWake = ctlQ[`HPRC_CTL_MWAKE] && (ev[`HPRC_EV_M0] || ev[`HPRC_EV_M1]);
    assign entryOk = (ctlQ[`HPRC_CTL_PWAKE] || ctlQ[`HPRC_CTL_MWAKE]) &&
        !(ctlQ[`HPRC_CTL_ABORT] && rawQ[`HPRC_EV_LB]);

    // Retained words
    hprc_retained_mem #(.DEPTH(MEM_DEPTH), .AW(6)) uMem (
        .clk(clk),
        .wrEn(wrStb && inData),
        .wrAddr(memIdx),
        .wrData(wrData),
        .rdAddr(memIdx),
        .rdData(memRd)
    );

    // Edge detect on the crystal tick; reset level matches the synchroniser's
    always_ff @(posedge clk) begin
        if (srst) begin
            xtalPrevQ <= 1'b0;
        end else begin
            xtalPrevQ <= xtalSync;
        end
    end

    // Edge detect on the oscillator tick
    always_ff @(posedge clk) begin
        if (srst) begin
            oscPrevQ <= 1'b0;
        end else begin
            oscPrevQ <= oscSync;
        end
    end

    // Crystal divide-by-128 prescaler
    always_ff @(posedge clk) begin
        if (srst) begin
            xdivQ <= 7'h00;
        end else if (xtalSync && !xtalPrevQ) begin
            xdivQ <= xdivQ + 7'h01;
        end
    end

    // Reference tick selected by bit 2 of control
    always_comb begin
        if (!ctlQ[`HPRC_CTL_CLKEN]) begin
            refTick = 1'b0;
        end else if (ctlQ[`HPRC_CTL_SEL]) begin
            refTick = oscSync && !oscPrevQ;
        end else begin
            refTick = xtalSync && !xtalPrevQ && (xdivQ == `HPRC_XTAL_DIV);
        end
    end

    // Predivider counting down reference ticks
    always_ff @(posedge clk) begin
        if (srst) begin
            predivQ <= `HPRC_NOMINAL_DIV;
            trimSecQ <= 6'h00;
        end else if (ctlQ[`HPRC_CTL_CNTEN] && refTick) begin
            if (predivQ == 16'h0000) begin
                trimSecQ <= trimSecQ + 6'h01;
                // Trimmed count on the last second of every 64
                if (trimSecQ == (`HPRC_TRIM_PERIOD - 6'h01)) begin
                    predivQ <= trimQ;
                end else begin
                    predivQ <= `HPRC_NOMINAL_DIV;
                end
            end else begin
                predivQ <= predivQ - 16'h0001;
            end
        end
    end
    assign secTick = ctlQ[`HPRC_CTL_CNTEN] && refTick && (predivQ == 16'h0000);

    // Seconds counter with load
    always_ff @(posedge clk) begin
        if (srst) begin
            countQ <= 32'h00000000;
        end else if (wrLoad) begin
            countQ <= wrData;
        end else if (secTick) begin
            countQ <= countQ + 32'h00000001;
        end
    end

    // Event sources
    always_comb begin
        ev = 4'h0;
        ev[`HPRC_EV_M0] = ctlQ[`HPRC_CTL_CNTEN] && (countQ == match0Q);
        ev[`HPRC_EV_M1] = ctlQ[`HPRC_CTL_CNTEN] && (countQ == match1Q);
        ev[`HPRC_EV_LB] = ctlQ[`HPRC_CTL_LBEN] && lbSync && !regulator_off_n;
        ev[`HPRC_EV_WAKE] = wakeSync && ctlQ[`HPRC_CTL_PWAKE];
    end

    // Raw status: set beats clear
    always_ff @(posedge clk) begin
        if (srst) begin
            rawQ <= 4'h0;
        end else begin
            rawQ <= (rawQ & ~clrBits) | ev;
        end
    end

    // Power state machine
    always_ff @(posedge clk) begin
        if (srst) begin
            stateQ <= hprc_pkg::HPRC_AWAKE;
        end else begin
            case (stateQ)
                hprc_pkg::HPRC_AWAKE: begin
                    // Enter only with a wake source armed and, when abort is set, no low-battery event
                    if (ctlQ[`HPRC_CTL_HIBREQ] && entryOk) begin
                        stateQ <= hprc_pkg::HPRC_HIBERNATE;
                    end
                end
                hprc_pkg::HPRC_HIBERNATE: begin
                    // Either armed source ends the power cut
                    if (pinWake || matchWake) begin
                        stateQ <= hprc_pkg::HPRC_WAKING;
                    end
                end
                hprc_pkg::HPRC_WAKING: begin
                    // One cycle for the chip reset pulse
                    stateQ <= hprc_pkg::HPRC_AWAKE;
                end
                default: begin
                    stateQ <= hprc_pkg::HPRC_AWAKE;
                end
            endcase
        end
    end

    // Control register; request bit self-clears on wake
    always_ff @(posedge clk) begin
        if (srst) begin
            ctlQ <= 8'h00;
        end else if (wrCtl) begin
            ctlQ <= wrData[7:0];
        end else if (stateQ == hprc_pkg::HPRC_WAKING) begin
            ctlQ[`HPRC_CTL_HIBREQ] <= 1'b0;
        end
    end

    // First match register
    always_ff @(posedge clk) begin
        if (srst) begin
            match0Q <= `HPRC_RST_MATCH;
        end else if (wrMatch0) begin
            match0Q <= wrData;
        end
    end

    // Second match register
    always_ff @(posedge clk) begin
        if (srst) begin
            match1Q <= `HPRC_RST_MATCH;
        end else if (wrMatch1) begin
            match1Q <= wrData;
        end
    end

    // Predivider trim, used for one second in every 64
    always_ff @(posedge clk) begin
        if (srst) begin
            trimQ <= `HPRC_RST_TRIM;
        end else if (wrTrim) begin
            trimQ <= wrData[15:0];
        end
    end

    // Event mask for the merged interrupt
    always_ff @(posedge clk) begin
        if (srst) begin
            maskQ <= 4'h0;
        end else if (wrMask) begin
            maskQ <= wrData[3:0];
        end
    end

    // Read mux, registered
    always_ff @(posedge clk) begin
        if (srst) begin
            regRdQ <= 32'h00000000;
            rdDataSelQ <= 1'b0;
        end else begin
            rdDataSelQ <= rdStb && inData;
            regRdQ <= 32'h00000000;
            if (rdStb) begin
                case (addr)
                    `HPRC_OFF_COUNT: regRdQ <= countQ;
                    `HPRC_OFF_MATCH0: regRdQ <= match0Q;
                    `HPRC_OFF_MATCH1: regRdQ <= match1Q;
                    `HPRC_OFF_LOAD: regRdQ <= countQ;
                    `HPRC_OFF_CTRL: regRdQ <= {24'h000000, ctlQ};
                    `HPRC_OFF_MASK: regRdQ <= {28'h0000000, maskQ};
                    `HPRC_OFF_RAW: regRdQ <= {28'h0000000, rawQ};
                    `HPRC_OFF_MIS: regRdQ <= {28'h0000000, rawQ & maskQ};
                    `HPRC_OFF_TRIM: regRdQ <= {16'h0000, trimQ};
                    default: regRdQ <= 32'h00000000;
                endcase
            end
        end
    end
    assign rdData = rdDataSelQ ? memRd : regRdQ;

    // Regulator enable, low while the main supply is cut
    always_ff @(posedge clk) begin
        if (srst) begin
            regulatorOff_n <= 1'b1;
        end else begin
            regulatorOff_n <= !regulator_off_n;
        end
    end

    // Single merged interrupt from the masked events
    always_ff @(posedge clk) begin
        if (srst) begin
            eventIrq <= 1'b0;
        end else begin
            eventIrq <= |(rawQ & maskQ);
        end
    end

    // Copy of the clock enable bit for the reference source
    always_ff @(posedge clk) begin
        if (srst) begin
            slowClockEnable <= 1'b0;
        end else begin
            slowClockEnable <= ctlQ[`HPRC_CTL_CLKEN];
        end
    end

    // Chip reset pulse in the cycle after the waking cycle
    always_ff @(posedge clk) begin
        if (srst) begin
            chipPorReset <= 1'b0;
        end else begin
            chipPorReset <= (stateQ == hprc_pkg::HPRC_WAKING);
        end
    end
endmodule // hprc_controller

// [testbench/hprc_controller_assertions.sv]
// Port checker for the power controller
`timescale 1ns/1ps
module hprc_controller_assertions (
    input wire logic clk,
    input wire logic srst,
    input wire logic [11:0] addr,
    input wire logic [31:0] wrData,
    input wire logic wrStb,
    input wire logic rdStb,
    input wire logic [31:0] rdData,
    input wire logic wakePin_n,
    input wire logic regulatorOff_n,
    input wire logic eventIrq,
    input wire logic slowClockEnable,
    input wire logic chipPorReset
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);
    logic pinArm_q; // Last written pin wake arm
    // Track pin wake arm from control writes
    always_ff @(posedge clk) begin
        if (srst) begin
            pinArm_q <= 1'b0;
        end else if (wrStb && addr == 12'h010) begin
            pinArm_q <= wrData[4];
        end
    end
    // Request with a wake source and no abort
    sequence s_hib_req;
        wrStb && addr == 12'h010 && wrData[1] && (wrData[3] || wrData[4]) && !wrData[7];
    endsequence
    // Armed pin pressed while power is off
    sequence s_pin_press;
        pinArm_q && $fell(wakePin_n) && !regulatorOff_n;
    endsequence
    a_hib_entry: assert property (s_hib_req |-> ##[1:4] !regulatorOff_n)
        else $error("power not cut after request");
    a_hib_no_source: assert property (wrStb && addr == 12'h010 && wrData[1] && !wrData[3]
        && !wrData[4] && regulatorOff_n |=> regulatorOff_n [*6])
        else $error("power cut with no wake source");
    a_pin_wake: assert property (s_pin_press |-> ##[1:12] regulatorOff_n)
        else $error("pin did not restore power");
    a_por_on_wake: assert property ($rose(regulatorOff_n) |->
        chipPorReset || $past(chipPorReset) || $past(chipPorReset, 2))
        else $error("no reset pulse at wake");
    a_por_pulse: assert property (chipPorReset |=> !chipPorReset)
        else $error("reset pulse too long");
    a_mask_irq: assert property (wrStb && addr == 12'h014 && wrData[3:0] == 4'h0
        ##1 !(wrStb && addr == 12'h014) [*2] |=> !eventIrq)
        else $error("interrupt with empty mask");
    a_store_back: assert property (wrStb && addr == 12'h030 ##1 !wrStb && !rdStb
        ##1 rdStb && addr == 12'h030 |=> rdData == $past(wrData, 3))
        else $error("stored word lost");
    a_clk_en_copy: assert property (wrStb && addr == 12'h010 |-> ##2
        slowClockEnable == $past(wrData[6], 2))
        else $error("clock enable not copied");
    a_unmapped_zero: assert property (rdStb && addr == 12'hffc |=> rdData == 32'h0)
        else $error("unmapped read not zero");
endmodule // hprc_controller_assertions
bind hprc_controller hprc_controller_assertions u_chk (.clk(clk), .srst(srst),
    .addr(addr), .wrData(wrData), .wrStb(wrStb), .rdStb(rdStb), .rdData(rdData),
    .wakePin_n(wakePin_n), .regulatorOff_n(regulatorOff_n), .eventIrq(eventIrq),
    .slowClockEnable(slowClockEnable), .chipPorReset(chipPorReset));

// [testbench/hprc_partner.sv]
// Far side: regulator, wake button, battery sense, references
`timescale 1ns/1ps
module hprc_partner (
    input wire logic regulatorOff_n,
    input wire logic wakeCmd,
    input wire logic lowBatCmd,
    output logic xtalTick,
    output logic oscTick,
    output logic wakePin_n,
    output logic lowBatteryDet,
    output logic mainPower
);
    // Pulled-up pin, low only while pressed
    assign wakePin_n = !wakeCmd;
    // Comparator level, high while battery sags
    assign lowBatteryDet = lowBatCmd;
    // Regulator follows its active-high enable
    assign mainPower = regulatorOff_n;
    // References always run, unrelated to clk
    initial begin
        xtalTick = 1'b0;
        forever #7.3 xtalTick = !xtalTick;
    end
    initial begin
        oscTick = 1'b0;
        forever #21.1 oscTick = !oscTick;
    end
endmodule // hprc_partner

// [testbench/tb_hprc_controller.sv]
// Self-checking bench for the power controller
`timescale 1ns/1ps
module tb_hprc_controller;
    logic clk, srst, wrStb, rdStb, wakeCmd, lowBatCmd;
    logic porSeen = 1'b0;
    logic [11:0] addr;
    logic [31:0] wrData, rdData, rv, x;
    logic xtalTick, oscTick, wakePin_n, lowBatteryDet, mainPower;
    logic regulatorOff_n, eventIrq, slowClockEnable, chipPorReset;
    int errors = 0;
    int n_checks = 0;
    int cyc = 0;
    logic [31:0] mem [8];
    logic [11:0] ma [8];
    logic [11:0] ra [9] = '{12'h0, 12'h4, 12'h8, 12'h10, 12'h14, 12'h18, 12'h1c, 12'h24, 12'hffc};
    logic [31:0] rr [9] = '{0, 32'hffffffff, 32'hffffffff, 0, 0, 0, 0, 32'h7fff, 0};
    hprc_controller uut (.clk(clk), .srst(srst), .addr(addr), .wrData(wrData),
        .wrStb(wrStb), .rdStb(rdStb), .rdData(rdData), .xtalTick(xtalTick),
        .oscTick(oscTick), .wakePin_n(wakePin_n), .lowBatteryDet(lowBatteryDet),
        .regulatorOff_n(regulatorOff_n), .eventIrq(eventIrq),
        .slowClockEnable(slowClockEnable), .chipPorReset(chipPorReset));
    hprc_partner far (.regulatorOff_n(regulatorOff_n), .wakeCmd(wakeCmd),
        .lowBatCmd(lowBatCmd), .xtalTick(xtalTick), .oscTick(oscTick),
        .wakePin_n(wakePin_n), .lowBatteryDet(lowBatteryDet), .mainPower(mainPower));
    // 250 MHz clock
    initial begin
        clk = 1'b0;
        forever #2 clk = !clk;
    end
    // Watchdog and wake reset pulse catcher
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (chipPorReset === 1'b1) porSeen <= 1'b1;
        if (cyc == 20000) begin
            errors = errors + 1;
            close_out();
        end
    end
    task automatic close_out();
        $display("checks %0d mismatches %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask
    // Spaced single write
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wrData <= d;
        wrStb <= 1'b1;
        @(posedge clk);
        wrStb <= 1'b0;
    endtask
    // Read, data taken the cycle after
    task automatic rd(input logic [11:0] a);
        @(posedge clk);
        addr <= a;
        rdStb <= 1'b1;
        @(posedge clk);
        rdStb <= 1'b0;
        #1 rv = rdData;
    endtask
    // Expected status word with one event bit set
    function automatic logic [31:0] evBit(input int b);
        return 32'h1 << b;
    endfunction
    task automatic waitReg(input logic e);
        repeat (40) if (regulatorOff_n !== e) @(posedge clk);
        chk("regulatorOff_n", {31'h0, e}, {31'h0, regulatorOff_n});
    endtask
    initial begin
        srst <= 1'b1;
        {wrStb, rdStb, addr, wrData, wakeCmd, lowBatCmd} <= '0;
        x = $urandom(81731);
        repeat (6) @(posedge clk);
        srst <= 1'b0;
        foreach (ra[i]) begin
            rd(ra[i]);
            chk("reset value", rr[i], rv);
        end
        wr(12'h010, 32'h44);
        rd(12'h010);
        chk("control", 32'h44, rv);
        chk("slowClockEnable", 1, {31'h0, slowClockEnable});
        x = $urandom;
        wr(12'h024, {16'h0, x[15:0]});
        rd(12'h024);
        chk("trim", {16'h0, x[15:0]}, rv);
        for (int i = 0; i < 8; i++) begin
            // Corner case: the first word of the window is always hit
            ma[i] = (i == 0) ? 12'h030 : 12'h030 + 12'(i * 32 + ($urandom % 8) * 4);
            mem[i] = $urandom;
            @(posedge clk);
            addr <= ma[i];
            wrData <= mem[i];
            wrStb <= 1'b1;
            @(posedge clk);
            wrStb <= 1'b0;
            @(posedge clk);
            rdStb <= 1'b1;
            @(posedge clk);
            rdStb <= 1'b0;
            #1 chk("word", mem[i], rdData);
        end
        $display("registers done");
        x = $urandom;
        wr(12'h004, x);
        wr(12'h00c, x);
        wr(12'h014, 32'h1);
        repeat (10) @(posedge clk);
        rd(12'h018);
        chk("raw stopped", 0, rv);
        wr(12'h010, 32'h45);
        repeat (10) @(posedge clk);
        rd(12'h018);
        chk("raw match", evBit(0), rv);
        rd(12'h01c);
        chk("masked", 1, rv);
        chk("eventIrq", 1, {31'h0, eventIrq});
        wr(12'h014, 32'h0);
        repeat (4) @(posedge clk);
        chk("eventIrq", 0, {31'h0, eventIrq});
        rd(12'h018);
        chk("raw unmasked", 1, rv);
        wr(12'h010, 32'h44);
        wr(12'h020, 32'h1);
        repeat (6) @(posedge clk);
        rd(12'h018);
        chk("raw cleared", 0, rv);
        $display("match done");
        wr(12'h010, 32'h64);
        lowBatCmd <= 1'b1;
        repeat (10) @(posedge clk);
        rd(12'h018);
        chk("raw low battery", evBit(2), rv);
        wr(12'h014, 32'h4);
        repeat (4) @(posedge clk);
        chk("eventIrq", 1, {31'h0, eventIrq});
        wr(12'h010, 32'hf6);
        repeat (20) @(posedge clk);
        chk("regulatorOff_n", 1, {31'h0, regulatorOff_n});
        lowBatCmd <= 1'b0;
        wr(12'h010, 32'h44);
        wr(12'h020, 32'h4);
        wr(12'h014, 32'h0);
        wr(12'h010, 32'h42);
        repeat (10) @(posedge clk);
        chk("regulatorOff_n", 1, {31'h0, regulatorOff_n});
        wr(12'h010, 32'h44);
        $display("battery done");
        wr(12'h010, 32'h56);
        waitReg(1'b0);
        chk("mainPower", 0, {31'h0, mainPower});
        wakeCmd <= 1'b1;
        waitReg(1'b1);
        @(posedge clk);
        chk("wake reset", 1, {31'h0, porSeen});
        wakeCmd <= 1'b0;
        rd(12'h018);
        chk("raw wake", evBit(3), rv & evBit(3));
        rd(12'h010);
        chk("request bit", 0, rv & 32'h2);
        foreach (ma[i]) begin
            rd(ma[i]);
            chk("retained", mem[i], rv);
        end
        wr(12'h020, 32'h8);
        wr(12'h008, 32'h64);
        wr(12'h00c, 32'h0);
        wr(12'h010, 32'h4b);
        waitReg(1'b0);
        wakeCmd <= 1'b1;
        repeat (8) @(posedge clk);
        chk("regulatorOff_n", 0, {31'h0, regulatorOff_n});
        wakeCmd <= 1'b0;
        wr(12'h00c, 32'h64);
        waitReg(1'b1);
        rd(12'h018);
        chk("raw match wake", 2, rv & 32'h2);
        $display("wake done");
        close_out();
    end
endmodule // tb_hprc_controller
